// ===== src/ldc_pkg.sv
package ldc_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int LDC_CLK_HZ = 50_000_000;
   localparam int LDC_CLK_MHZ = 50;
   localparam int LDC_CLK_NS = 20;

   // full ramp durations, microseconds
   localparam int LDC_RAMP_FAST_US = 15_000;
   localparam int LDC_RAMP_HALF_US = 500_000;
   localparam int LDC_RAMP_ONE_US = 1_000_000;
   localparam int LDC_RAMP_TWO_US = 2_000_000;
   localparam int LDC_RAMP_STEPS = 63;
   localparam int LDC_RAMP_W = 22;

   // pwm base clock rates, hertz
   localparam int LDC_BASE0_HZ = 8770;
   localparam int LDC_BASE1_HZ = 4390;
   localparam int LDC_BASE2_HZ = 2920;
   localparam int LDC_BASE3_HZ = 2190;
   localparam int LDC_DIV_W = 16;

   // glitch filter: pulses shorter than this are dropped
   localparam int LDC_FILT_NS = 50;
   localparam int LDC_FILT_CYC = (LDC_FILT_NS + LDC_CLK_NS - 1) / LDC_CLK_NS;
   localparam int LDC_FILT_W = 3;

   // ----------------------------------------------------------------
   // serial port
   // ----------------------------------------------------------------
   localparam int LDC_BYTE_W = 8;
   localparam logic [7:0] LDC_WR_ADDR = 8'h12;
   localparam logic [7:0] LDC_RD_ADDR = 8'h13;
   localparam logic [3:0] LDC_BIT_LAST = 4'h8;
   localparam logic [3:0] LDC_TX_LAST = 4'h7;
   localparam int LDC_NUM_REGS = 4;
   localparam logic [1:0] LDC_SUB_BUCK = 2'h0;
   localparam logic [1:0] LDC_SUB_CTRL = 2'h1;
   localparam logic [1:0] LDC_SUB_DAC = 2'h2;
   localparam logic [1:0] LDC_SUB_PWM = 2'h3;
   localparam logic [7:0] LDC_REG_RST = 8'h00;

   // ----------------------------------------------------------------
   // field layout
   // ----------------------------------------------------------------
   localparam int LDC_EN_BIT = 0;
   localparam int LDC_RAMP_A_BIT = 1;
   localparam int LDC_RAMP_B_BIT = 2;
   localparam int LDC_MODE_A_BIT = 3;
   localparam int LDC_MODE_B_BIT = 4;
   localparam int LDC_BASE_A_BIT = 5;
   localparam int LDC_BASE_B_BIT = 6;
   localparam int LDC_DAC_W = 6;
   localparam int LDC_CNT_W = 4;
   localparam int LDC_HIGH_LSB = 4;
   localparam int LDC_PERIOD_LSB = 0;

   // one-hot serial port states
   typedef enum logic [6:0] {
      LDC_ST_IDLE = 7'h01,
      LDC_ST_ADDR = 7'h02,
      LDC_ST_SUB = 7'h04,
      LDC_ST_DATA = 7'h08,
      LDC_ST_ACK = 7'h10,
      LDC_ST_READ = 7'h20,
      LDC_ST_SKIP = 7'h40
   } ldc_port_state_type;

endpackage

// ===== src/ldc_pwm_if.sv
`timescale 1ns/1ns
interface ldc_pwm_if;
   import ldc_pkg::*;
   logic base_tick;
   logic run;
   logic [LDC_CNT_W-1:0] high_count;
   logic [LDC_CNT_W-1:0] period_count;
   logic pwm_on;

   modport ctrl (
      output base_tick,
      output run,
      output high_count,
      output period_count,
      input pwm_on
   );

   modport gen (
      input base_tick,
      input run,
      input high_count,
      input period_count,
      output pwm_on
   );
endinterface

// ===== src/ldc_pwm_gen.sv
`timescale 1ns/1ns
module ldc_pwm_gen (
   input wire logic clk_in,
   input wire logic rst_n_in,
   ldc_pwm_if.gen pwm_bus
);
   import ldc_pkg::*;

   logic [LDC_CNT_W-1:0] phase;
   logic period_zero;
   logic phase_wrap;
   logic next_on;

   // ----------------------------------------------------------------
   // phase counter over base clock ticks
   // ----------------------------------------------------------------
   assign period_zero = (pwm_bus.period_count == '0);
   assign phase_wrap = (phase >= pwm_bus.period_count - 1'b1);
   // high count above period: phase always below it, so full duty
   assign next_on = pwm_bus.run & ~period_zero
      & (phase < pwm_bus.high_count);

   // counter restarts whenever the generator is idle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase <= '0;
      end else if (!pwm_bus.run || period_zero) begin
         phase <= '0;
      end else if (pwm_bus.base_tick) begin
         phase <= phase_wrap ? '0 : phase + 1'b1;
      end
   end

   // registered so the sink and boost gates never see a glitch
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pwm_bus.pwm_on <= 1'b0;
      end else begin
         pwm_bus.pwm_on <= next_on;
      end
   end
endmodule

// ===== src/ldc_top.sv
`timescale 1ns/1ns

module ldc_top #(
   parameter int RAMP_STEP0 = ldc_pkg::LDC_RAMP_FAST_US
      * ldc_pkg::LDC_CLK_MHZ / ldc_pkg::LDC_RAMP_STEPS,
   parameter int RAMP_STEP1 = ldc_pkg::LDC_RAMP_HALF_US
      * ldc_pkg::LDC_CLK_MHZ / ldc_pkg::LDC_RAMP_STEPS,
   parameter int RAMP_STEP2 = ldc_pkg::LDC_RAMP_ONE_US
      * ldc_pkg::LDC_CLK_MHZ / ldc_pkg::LDC_RAMP_STEPS,
   parameter int RAMP_STEP3 = ldc_pkg::LDC_RAMP_TWO_US
      * ldc_pkg::LDC_CLK_MHZ / ldc_pkg::LDC_RAMP_STEPS,
   parameter int BASE_DIV0 = ldc_pkg::LDC_CLK_HZ
      / ldc_pkg::LDC_BASE0_HZ,
   parameter int BASE_DIV1 = ldc_pkg::LDC_CLK_HZ
      / ldc_pkg::LDC_BASE1_HZ,
   parameter int BASE_DIV2 = ldc_pkg::LDC_CLK_HZ
      / ldc_pkg::LDC_BASE2_HZ,
   parameter int BASE_DIV3 = ldc_pkg::LDC_CLK_HZ
      / ldc_pkg::LDC_BASE3_HZ
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic uvlo_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic [ldc_pkg::LDC_BYTE_W-1:0] status_in,
   output logic [ldc_pkg::LDC_BYTE_W-1:0] buck_ctrl_out,
   output logic [ldc_pkg::LDC_DAC_W-1:0] led_code_out,
   output logic led_active_out,
   output logic sink_on_out,
   output logic boost_on_out,
   output logic standby_src_out,
   output logic boost_fb_mode_out,
   output logic pwm_out
);
   import ldc_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [1:0] raw_line;
   logic [1:0] filt_line;
   logic scl_f;
   logic sda_f;
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   ldc_port_state_type state;
   ldc_port_state_type next_state;
   ldc_port_state_type after_ack;
   ldc_port_state_type next_after;
   ldc_port_state_type ack_target;
   logic [3:0] bit_cnt;
   logic [3:0] next_cnt;
   logic [7:0] shreg;
   logic [7:0] tx;
   logic [7:0] next_tx;
   logic next_oe;
   logic rx_state;
   logic byte_done;
   logic addr_wr;
   logic addr_rd;
   logic [1:0] sub_sel;
   logic hold_we;
   logic pending;
   logic commit;

   logic [7:0] hold [LDC_NUM_REGS];
   logic [7:0] act [LDC_NUM_REGS];

   logic [7:0] ctrl;
   logic led_en;
   logic [1:0] ramp_sel;
   logic [1:0] base_sel;
   logic drive_mode_bit_a;
   logic drive_mode_bit_b;
   logic mode_pwm;
   logic mode_boost;
   logic mode_cc;
   logic [LDC_DAC_W-1:0] dac_code;
   logic [LDC_DAC_W-1:0] target;
   logic [LDC_DAC_W-1:0] level;
   logic [LDC_RAMP_W-1:0] ramp_cnt;
   logic [LDC_RAMP_W-1:0] ramp_lim;
   logic ramp_step;
   logic driver_active;
   logic [LDC_DIV_W-1:0] div_cnt;
   logic [LDC_DIV_W-1:0] div_lim;
   logic base_tick;

   ldc_pwm_if pwm_bus ();

   // ----------------------------------------------------------------
   // input glitch filters
   // ----------------------------------------------------------------
   // a line only changes after it has held its new level for
   // the whole filter window; costs a few cycles of latency
   assign raw_line = {scl_in, sda_in};

   for (genvar g = 0; g < 2; g++) begin : g_filt
      logic [LDC_FILT_W-1:0] cnt;
      logic val;
      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            cnt <= '0;
            val <= 1'b1;
         end else if (raw_line[g] == val) begin
            cnt <= '0;
         end else if (cnt == LDC_FILT_W'(LDC_FILT_CYC - 1)) begin
            cnt <= '0;
            val <= raw_line[g];
         end else begin
            cnt <= cnt + 1'b1;
         end
      end
      assign filt_line[g] = val;
   end

   assign scl_f = filt_line[1];
   assign sda_f = filt_line[0];

   // previous filtered levels for edge detection
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_f;
         sda_q <= sda_f;
      end
   end

   // bus events; both lines idle high between transfers
   assign scl_rise = scl_f & ~scl_q;
   assign scl_fall = ~scl_f & scl_q;
   assign start_det = scl_f & scl_q & sda_q & ~sda_f;
   assign stop_det = scl_f & scl_q & ~sda_q & sda_f;

   // ----------------------------------------------------------------
   // serial slave state machine
   // ----------------------------------------------------------------
   assign rx_state = (state == LDC_ST_ADDR) | (state == LDC_ST_SUB)
      | (state == LDC_ST_DATA);
   assign byte_done = rx_state & scl_fall & (bit_cnt == LDC_BIT_LAST);
   assign addr_wr = (shreg == LDC_WR_ADDR);
   assign addr_rd = (shreg == LDC_RD_ADDR);
   // exactly three bytes per write, then ignore until start
   assign ack_target = (state == LDC_ST_ADDR)
      ? (addr_rd ? LDC_ST_READ : LDC_ST_SUB)
      : ((state == LDC_ST_SUB) ? LDC_ST_DATA : LDC_ST_SKIP);
   assign hold_we = byte_done & (state == LDC_ST_DATA);

   // next state, counters and data line drive
   always_comb begin
      next_state = state;
      next_after = after_ack;
      next_cnt = bit_cnt;
      next_oe = sda_oe_out;
      next_tx = tx;
      if (start_det) begin
         next_state = LDC_ST_ADDR;
         next_cnt = '0;
         next_oe = 1'b0;
      end else if (stop_det) begin
         next_state = LDC_ST_IDLE;
         next_oe = 1'b0;
      end else begin
         case (state)
            LDC_ST_ADDR, LDC_ST_SUB, LDC_ST_DATA: begin
               if (scl_rise) begin
                  next_cnt = bit_cnt + 1'b1;
               end else if (byte_done) begin
                  next_cnt = '0;
                  if (state == LDC_ST_ADDR && !addr_wr && !addr_rd) begin
                     next_state = LDC_ST_SKIP; // not our address
                  end else begin
                     next_state = LDC_ST_ACK;
                     next_after = ack_target;
                     next_oe = 1'b1;
                  end
               end
            end
            LDC_ST_ACK: begin
               if (scl_fall) begin
                  next_state = after_ack;
                  next_oe = 1'b0;
                  if (after_ack == LDC_ST_READ) begin
                     next_tx = status_in;
                     next_oe = ~status_in[7];
                  end
               end
            end
            LDC_ST_READ: begin
               if (scl_fall) begin
                  next_cnt = bit_cnt + 1'b1;
                  if (bit_cnt == LDC_TX_LAST) begin
                     // release for the master's acknowledge
                     next_oe = 1'b0;
                     next_state = LDC_ST_SKIP;
                  end else begin
                     next_tx = {tx[6:0], 1'b0};
                     next_oe = ~tx[6];
                  end
               end
            end
            LDC_ST_IDLE, LDC_ST_SKIP: begin
               next_state = state;
            end
            default: begin
               next_state = LDC_ST_IDLE;
               next_oe = 1'b0;
            end
         endcase
      end
   end

   // state registers; undervoltage drops any transfer at once
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= LDC_ST_IDLE;
         after_ack <= LDC_ST_IDLE;
         bit_cnt <= '0;
         tx <= '0;
         sda_oe_out <= 1'b0;
      end else if (uvlo_in) begin
         state <= LDC_ST_IDLE;
         after_ack <= LDC_ST_IDLE;
         bit_cnt <= '0;
         tx <= '0;
         sda_oe_out <= 1'b0;
      end else begin
         state <= next_state;
         after_ack <= next_after;
         bit_cnt <= next_cnt;
         tx <= next_tx;
         sda_oe_out <= next_oe;
      end
   end

   // msb first receive shift and sub-address pointer
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         shreg <= '0;
         sub_sel <= '0;
      end else if (uvlo_in) begin
         shreg <= '0;
         sub_sel <= '0;
      end else begin
         if (rx_state && scl_rise) begin
            shreg <= {shreg[6:0], sda_f};
         end
         if (byte_done && state == LDC_ST_SUB) begin
            sub_sel <= shreg[1:0]; // upper pointer bits alias
         end
      end
   end

   // open drain: the pad only ever pulls low
   assign sda_out = 1'b0;

   // ----------------------------------------------------------------
   // holding and active setting latches
   // ----------------------------------------------------------------
   // any stop, even after other chips were addressed, commits
   assign commit = stop_det & pending;

   // a write landing with the stop still counts as pending
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pending <= 1'b0;
      end else if (uvlo_in) begin
         pending <= 1'b0;
      end else begin
         pending <= hold_we | (pending & ~commit);
      end
   end

   for (genvar r = 0; r < LDC_NUM_REGS; r++) begin : g_reg
      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            hold[r] <= LDC_REG_RST;
            act[r] <= LDC_REG_RST;
         end else if (uvlo_in) begin
            hold[r] <= LDC_REG_RST;
            act[r] <= LDC_REG_RST;
         end else begin
            if (hold_we && sub_sel == 2'(r)) begin
               hold[r] <= shreg;
            end
            if (commit) begin
               act[r] <= hold[r];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // setting decode
   // ----------------------------------------------------------------
   assign ctrl = act[LDC_SUB_CTRL];
   assign led_en = ctrl[LDC_EN_BIT];
   assign ramp_sel = {ctrl[LDC_RAMP_B_BIT], ctrl[LDC_RAMP_A_BIT]};
   assign base_sel = {ctrl[LDC_BASE_B_BIT], ctrl[LDC_BASE_A_BIT]};
   assign drive_mode_bit_a = ctrl[LDC_MODE_A_BIT];
   assign drive_mode_bit_b = ctrl[LDC_MODE_B_BIT];
   assign mode_pwm = ~drive_mode_bit_a & drive_mode_bit_b;
   assign mode_boost = drive_mode_bit_a & ~drive_mode_bit_b;
   // both bits set is not a defined mode; fall back to cc
   assign mode_cc = ~mode_pwm & ~mode_boost;
   assign dac_code = act[LDC_SUB_DAC][LDC_DAC_W-1:0];

   // ----------------------------------------------------------------
   // gradation ramp
   // ----------------------------------------------------------------
   // one dac step per interval, so a full 0..63 sweep takes the
   // chosen duration; shorter sweeps finish proportionally sooner
   assign ramp_lim = (ramp_sel == 2'h0) ? LDC_RAMP_W'(RAMP_STEP0 - 1)
      : (ramp_sel == 2'h1) ? LDC_RAMP_W'(RAMP_STEP1 - 1)
      : (ramp_sel == 2'h2) ? LDC_RAMP_W'(RAMP_STEP2 - 1)
      : LDC_RAMP_W'(RAMP_STEP3 - 1);
   assign target = led_en ? dac_code : '0;
   // at or above: a faster speed picked mid-wait must not strand the count
   assign ramp_step = (ramp_cnt >= ramp_lim);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ramp_cnt <= '0;
         level <= '0;
      end else if (level == target) begin
         ramp_cnt <= '0;
      end else if (ramp_step) begin
         ramp_cnt <= '0;
         level <= (level < target) ? level + 1'b1 : level - 1'b1;
      end else begin
         ramp_cnt <= ramp_cnt + 1'b1;
      end
   end

   // driver stays on until the ramp down has reached zero
   assign driver_active = led_en | (level != '0);

   // ----------------------------------------------------------------
   // pwm base clock and generator
   // ----------------------------------------------------------------
   assign div_lim = (base_sel == 2'h0) ? LDC_DIV_W'(BASE_DIV0 - 1)
      : (base_sel == 2'h1) ? LDC_DIV_W'(BASE_DIV1 - 1)
      : (base_sel == 2'h2) ? LDC_DIV_W'(BASE_DIV2 - 1)
      : LDC_DIV_W'(BASE_DIV3 - 1);
   assign base_tick = (div_cnt >= div_lim);

   // free running; a selection change applies at once to the count in progress
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_cnt <= '0;
      end else if (base_tick) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   assign pwm_bus.base_tick = base_tick;
   assign pwm_bus.run = mode_pwm & driver_active;
   assign pwm_bus.high_count =
      act[LDC_SUB_PWM][LDC_HIGH_LSB +: LDC_CNT_W];
   assign pwm_bus.period_count =
      act[LDC_SUB_PWM][LDC_PERIOD_LSB +: LDC_CNT_W];

   ldc_pwm_gen u_pwm (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .pwm_bus(pwm_bus.gen)
   );

   // ----------------------------------------------------------------
   // output drive
   // ----------------------------------------------------------------
   // sink and boost share the same pwm phase in pwm mode
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         led_code_out <= '0;
         led_active_out <= 1'b0;
         sink_on_out <= 1'b0;
         boost_on_out <= 1'b0;
         standby_src_out <= 1'b0;
         boost_fb_mode_out <= 1'b0;
         pwm_out <= 1'b0;
         buck_ctrl_out <= '0;
      end else begin
         led_code_out <= level;
         led_active_out <= driver_active;
         sink_on_out <= driver_active
            & (mode_cc | (mode_pwm & pwm_bus.pwm_on));
         boost_on_out <= driver_active
            & (~mode_pwm | pwm_bus.pwm_on);
         standby_src_out <= mode_pwm;
         boost_fb_mode_out <= mode_boost;
         pwm_out <= mode_pwm & pwm_bus.pwm_on;
         buck_ctrl_out <= act[LDC_SUB_BUCK];
      end
   end
endmodule

// ===== bench/ldc_monitor.sv
`timescale 1ns/1ns
module ldc_monitor (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic uvlo_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic [ldc_pkg::LDC_BYTE_W-1:0] status_in,
   input wire logic [ldc_pkg::LDC_BYTE_W-1:0] buck_ctrl_out,
   input wire logic [ldc_pkg::LDC_DAC_W-1:0] led_code_out,
   input wire logic led_active_out,
   input wire logic sink_on_out,
   input wire logic boost_on_out,
   input wire logic standby_src_out,
   input wire logic boost_fb_mode_out,
   input wire logic pwm_out
);
   import ldc_pkg::*;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // ----------------------------------------------------------------
   // port, ramp and mode relations
   // ----------------------------------------------------------------
   chk_uvlo_release: assert property (
      uvlo_in |=> !sda_oe_out) else $error("sda pulled in undervoltage");
   chk_uvlo_clear: assert property (
      uvlo_in ##1 uvlo_in |=> buck_ctrl_out == 8'h00)
      else $error("settings kept in undervoltage");
   // sda may only move while scl is low, else it fakes start or stop
   chk_sda_scl_low: assert property (
      $changed(sda_oe_out) && !$past(uvlo_in) |-> !scl_in)
      else $error("sda moved while scl high");
   chk_ramp_unit: assert property (
      $changed(led_code_out) |->
      (led_code_out - $past(led_code_out)) inside {6'h01, 6'h3F})
      else $error("led code jumped");
   chk_ramp_pace: assert property (
      $changed(led_code_out) |=> $stable(led_code_out) [*2])
      else $error("led code stepped too fast");
   chk_active_code: assert property (
      led_code_out != 6'h00 |-> led_active_out)
      else $error("current flows while inactive");
   chk_gate_pair: assert property (
      standby_src_out && $past(standby_src_out) |->
      sink_on_out == boost_on_out) else $error("sink and boost split");
   chk_boost_fb: assert property (
      boost_fb_mode_out && $past(boost_fb_mode_out) |->
      !sink_on_out && !standby_src_out) else $error("sink on in boost");
   chk_pwm_gated: assert property (
      !standby_src_out && !$past(standby_src_out) |-> !pwm_out)
      else $error("pwm outside pwm mode");
   cover property ($rose(pwm_out));
   cover property ($rose(sda_oe_out));
   cover property ($rose(boost_fb_mode_out));
endmodule

bind ldc_top ldc_monitor mon_u (.clk_in, .rst_n_in, .uvlo_in, .scl_in,
   .sda_in, .sda_out, .sda_oe_out, .status_in, .buck_ctrl_out,
   .led_code_out, .led_active_out, .sink_on_out, .boost_on_out,
   .standby_src_out, .boost_fb_mode_out, .pwm_out);

// ===== bench/ldc_i2c_master.sv
`timescale 1ns/1ns
module ldc_i2c_master #(
   parameter int Q = 32 // quarter bit, 128 clocks is 390 kHz
) (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_out
);
   // ----------------------------------------------------------------
   // bus master model
   // ----------------------------------------------------------------
   // both lines released while no transfer runs
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic step(input logic c, s, input int n = Q);
      scl_out = c;
      sda_out = s;
      repeat (n) @(negedge clk_in);
   endtask
   // start or repeated start; an address byte always follows
   task automatic start();
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
   // scl drops first so that sda falling never reads as a start
   task automatic stop();
      step(1'b0, sda_out);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   // one-clock sda dip under high scl, shorter than any filter
   task automatic glitch();
      step(1'b1, 1'b1);
      step(1'b1, 1'b0, 1);
      step(1'b1, 1'b1);
   endtask
   task automatic bit_x(input logic b, output logic s);
      step(1'b0, b);
      step(1'b1, b);
      s = sda_in;
      step(1'b1, b);
      step(1'b0, b);
   endtask
   // msb first, sda released for the ninth clock
   task automatic xfer(input logic [7:0] d, output logic [7:0] r,
      output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r[i]);
      end
      bit_x(1'b1, ack);
   endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ns
module testbench;
   import ldc_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic uvlo_in = 1'b0;
   logic [LDC_BYTE_W-1:0] status_in = 8'h00;
   logic scl_m, sda_m, sda_w, sda_oe_out, led_active_out, sink_on_out;
   logic boost_on_out, standby_src_out, boost_fb_mode_out, pwm_out;
   logic [LDC_BYTE_W-1:0] buck_ctrl_out;
   logic [LDC_DAC_W-1:0] led_code_out;
   logic [15:0] exp_q[$];
   logic [15:0] seen;
   logic [31:0] rnd = 32'h00015796;
   logic [7:0] pw[4] = '{8'h7C, 8'h04, 8'h95, 8'h34};
   int err_count = 0;
   int checks_done = 0;
   event seen_ev;
   // ----------------------------------------------------------------
   // wiring and tasks
   // ----------------------------------------------------------------
   // open-drain line with pull-up: either party may pull it low
   assign sda_w = sda_m & ~sda_oe_out;
   always #10 clk_in = ~clk_in;
   // short counts keep ramps and pwm periods within the run
   // slower ramp speeds keep their full counts; only their pace is seen
   ldc_top #(.RAMP_STEP0(4), .BASE_DIV0(3), .BASE_DIV1(4),
      .BASE_DIV2(5), .BASE_DIV3(6)) dut_u (.clk_in, .rst_n_in, .uvlo_in,
      .scl_in(scl_m), .sda_in(sda_w), .sda_out(), .sda_oe_out, .status_in,
      .buck_ctrl_out, .led_code_out, .led_active_out, .sink_on_out,
      .boost_on_out, .standby_src_out, .boost_fb_mode_out, .pwm_out);
   ldc_i2c_master mst (.clk_in, .sda_in(sda_w), .scl_out(scl_m),
      .sda_out(sda_m));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [15:0] s, e);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic note(input logic [15:0] e, s);
      exp_q.push_back(e);
      seen = s;
      -> seen_ev;
      #1;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic wr(input logic [7:0] sub, d);
      logic [7:0] r;
      logic a;
      mst.start();
      for (int i = 0; i < 3; i++) begin
         mst.xfer(i == 0 ? 8'h12 : (i == 1 ? sub : d), r, a);
         note(16'h0000, a);
      end
   endtask
   task automatic wrs(input logic [7:0] sub, d);
      wr(sub, d);
      mst.stop();
      cyc(10);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // watcher: each reported result against the oldest note
   always @(seen_ev) begin
      check(seen, exp_q.pop_front());
   end
   initial begin
      #2_000_000;
      err_count++;
      results();
   end
   // main sequence
   initial begin
      logic [7:0] r, d, b;
      logic [3:0] hi, per;
      logic a, p;
      int e, ed;
      cyc(4);
      rst_n_in = 1'b1;
      cyc(4);
      rnd = lfsr(rnd);
      d = {2'b10, rnd[3:0]};
      b = {rnd[15:9], 1'b1};
      wr(8'h02, d);
      wr(8'h00, b);
      wr(8'h01, 8'h01);
      mst.start();
      mst.xfer(8'h40, r, a);
      note(16'h0001, a);
      mst.glitch();
      note(16'h0000, buck_ctrl_out);
      mst.stop();
      cyc(10);
      note(b, buck_ctrl_out);
      note(16'h0001, led_code_out < d);
      cyc(300);
      note({d, 1'b1}, {led_code_out, sink_on_out});
      wrs(8'h01, 8'h00);
      note(16'h0001, led_active_out && led_code_out != 0);
      cyc(300);
      note(16'h0000, {led_code_out, led_active_out});
      // half-second speed: no step may show within a few hundred clocks
      wrs(8'h01, 8'h03);
      cyc(300);
      note(16'h0000, led_code_out);
      wrs(8'h01, 8'h09);
      note(16'h0009,
         {boost_fb_mode_out, standby_src_out, sink_on_out, boost_on_out});
      wrs(8'h01, 8'h19);
      note(16'h0003,
         {boost_fb_mode_out, standby_src_out, sink_on_out, boost_on_out});
      for (int i = 0; i < 4; i++) begin
         {hi, per} = pw[i];
         wr(8'h03, pw[i]);
         wrs(8'h01, {1'b0, i[1:0], 5'h11});
         cyc(100);
         e = 0;
         ed = 0;
         p = pwm_out;
         repeat (int'(per) * (3 + i) * 8) begin
            cyc(1);
            e += pwm_out;
            ed += pwm_out & !p;
            p = pwm_out;
         end
         note(hi == 0 ? 0 : (hi >= per ? per : hi) * (3 + i) * 8,
            e);
         note((hi != 0 && hi < per) ? 8 : 0, ed);
         note(16'h0001, standby_src_out);
      end
      status_in = rnd[23:16];
      mst.start();
      mst.xfer(8'h13, r, a);
      note(16'h0000, a);
      mst.xfer(8'hFF, r, a);
      note(status_in, r);
      mst.stop();
      uvlo_in = 1'b1;
      cyc(5);
      uvlo_in = 1'b0;
      cyc(3);
      note(16'h0000, {buck_ctrl_out, standby_src_out});
      results();
   end
endmodule
